// ==== sec_area_pkg.sv ====
package sec_area_pkg;
   // opcodes
   localparam logic [7:0] OP_PARAM_READ = 8'h5A;
   localparam logic [7:0] OP_AREA_ERASE = 8'h44;
   localparam logic [7:0] OP_AREA_PROGRAM = 8'h42;
   localparam logic [7:0] OP_AREA_READ = 8'h48;
   localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
   localparam logic [7:0] OP_RELEASE_PD = 8'hAB;
   // rising-edge counts within a frame (value before the edge)
   localparam logic [5:0] EDGE_FIRST = 6'h00;
   localparam logic [5:0] EDGE_OPCODE_LAST = 6'h07;
   localparam logic [5:0] EDGE_ADDR_FIRST = 6'h08;
   localparam logic [5:0] EDGE_ADDR_LAST = 6'h1F;
   localparam logic [5:0] CNT_ADDR_DONE = 6'h20;
   localparam logic [5:0] CNT_READ_DATA = 6'h28;
   // security area address layout
   localparam logic [7:0] AREA_HIGH_BYTE = 8'h00;
   localparam logic [3:0] AREA_MID_NIBBLE = 4'h0;
   localparam logic [3:0] AREA_SEL_FIRST = 4'h1;
   localparam logic [3:0] AREA_SEL_LAST = 4'h3;
   localparam int AREA_COUNT = 3;
   localparam int AREA_BYTES = 256;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] WALK_LAST = 8'hFF;
   // parameter table header; values are arbitrary
   localparam logic [31:0] PARAM_SIGNATURE = 32'h5054_424C;
   localparam logic [7:0] PARAM_REVISION = 8'h01;
   localparam logic [7:0] PARAM_AREA_COUNT = 8'h03;
   // block lock
   localparam int LOCK_IDX_LSB = 16;
   localparam int LOCK_UNITS_DEFAULT = 16;
   localparam logic LOCK_RESET = 1'b1;
   // timing
   localparam int CLK_PERIOD_PS = 10000;
   localparam int SECTOR_ERASE_TIME_US = 1000;
   localparam int PROGRAM_TIME_US = 10;
   localparam int SECTOR_ERASE_CYCLES =
      (SECTOR_ERASE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PROGRAM_CYCLES =
      (PROGRAM_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_PROGRAM = 2'b10
   } exec_state_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic exact8;
      logic exact32;
      logic has_data;
      logic tag;
   } frame_t;
endpackage

// ==== sec_area_engine.sv ====
`timescale 1ns/1ps
// How it works
// - 256-byte read-only parameter table, read by opcode 5A plus 24-bit address.
// - after address, eight dummy clocks; data MSB first from 40th falling edge.
// - host zeroes address 23..8; low byte is the starting table offset.
// - three separate 256-byte security areas, each erased and programmed alone.
// - area erase is opcode 44 plus address, accepted only with latch set.
// - area chosen by address 15..12 = 1..3; other fields fixed; offset ignored on erase.
// - erase runs only if chip select rises right after the 32nd bit.
// - erase is self-timed for the sector erase time with busy held high.
// - finished erase clears the write enable latch.
// - a set lock bit makes its area ignore erase and program.
// - area program is opcode 42, address, 1 to 256 bytes, latch required.
// - area read is opcode 48, address, eight dummies, sampled on rising edges.
// - read bytes go out MSB first on falling edges, offset auto-increments.
// - read offset wraps from FF to 00 in the same area.
// - read lasts until chip select rises.
// - area read while busy is ignored; running cycle unaffected.
// - lock bits protect only when scheme select is 1, else range bits decide.
// - block lock bits are volatile and come up as 1 after reset.
// - block lock is opcode 36 plus address then select high, latch required.
// - release-from-power-down is ignored while a cycle is running.
module sec_area_engine #(
   parameter int ERASE_CYCLES = sec_area_pkg::SECTOR_ERASE_CYCLES,
   parameter int PROGRAM_CYCLES = sec_area_pkg::PROGRAM_CYCLES,
   parameter int LOCK_UNITS = sec_area_pkg::LOCK_UNITS_DEFAULT
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SERIAL_INPUT,
   output logic SERIAL_OUTPUT,
   output logic SERIAL_OUTPUT_OE,
   input wire logic WEL_SET,
   output logic WRITE_ENABLE_LATCH,
   input wire logic [2:0] SECURITY_AREA_LOCK_BITS,
   input wire logic OTHER_BUSY,
   output logic BUSY,
   input wire logic PROTECTION_SCHEME_SELECT,
   input wire logic RANGE_PROTECTED,
   input wire logic [23:0] QUERY_ADDR,
   output logic QUERY_PROTECTED,
   output logic [LOCK_UNITS-1:0] BLOCK_LOCK_BITS,
   output logic RELEASE_POWER_DOWN
);
   localparam int LOCK_IW = (LOCK_UNITS > 1) ? $clog2(LOCK_UNITS) : 1;
   localparam int MEM_WORDS = sec_area_pkg::AREA_COUNT * sec_area_pkg::AREA_BYTES;

   function automatic logic area_ok(input logic [23:0] a);
      area_ok = (a[23:16] == sec_area_pkg::AREA_HIGH_BYTE) &&
                (a[11:8] == sec_area_pkg::AREA_MID_NIBBLE) &&
                (a[15:12] >= sec_area_pkg::AREA_SEL_FIRST) &&
                (a[15:12] <= sec_area_pkg::AREA_SEL_LAST);
   endfunction

   // area 1..3 maps to 0..2
   function automatic logic [1:0] area_num(input logic [23:0] a);
      area_num = 2'(a[13:12] - 2'h1);
   endfunction

   function automatic logic [7:0] table_byte(input logic [7:0] off);
      case (off)
         8'h00: table_byte = sec_area_pkg::PARAM_SIGNATURE[31:24];
         8'h01: table_byte = sec_area_pkg::PARAM_SIGNATURE[23:16];
         8'h02: table_byte = sec_area_pkg::PARAM_SIGNATURE[15:8];
         8'h03: table_byte = sec_area_pkg::PARAM_SIGNATURE[7:0];
         8'h04: table_byte = sec_area_pkg::PARAM_REVISION;
         8'h05: table_byte = sec_area_pkg::PARAM_AREA_COUNT;
         default: table_byte = sec_area_pkg::ERASED_BYTE;
      endcase
   endfunction

   // ---------------- link domain (SCLK) ----------------
   logic link_rst;
   logic [5:0] cnt_reg;
   logic [6:0] sh_reg;
   logic [7:0] in_byte;
   logic busy_s1_reg;
   logic busy_s2_reg;
   sec_area_pkg::frame_t frame_reg;
   logic rd_param_reg;
   logic rd_area_reg;
   logic prog_reg;
   logic [2:0] bit_reg;
   logic [7:0] off_reg;
   logic data_edge;
   logic [7:0] pbuf [0:255];
   // written on CLK, read here only while no cycle runs
   logic [7:0] mem [0:MEM_WORDS-1];
   logic [255:0] pmask_reg;
   logic [7:0] rd_byte;
   logic so_reg;
   logic oe_reg;

   // chip select high ends every frame even though SCLK then stands still
   assign link_rst = RST | CS_N;
   assign in_byte = {sh_reg, SERIAL_INPUT};

   always_ff @(posedge SCLK or posedge link_rst) begin
      if (link_rst) begin
         cnt_reg <= 6'h00;
      end else if (cnt_reg != sec_area_pkg::CNT_READ_DATA) begin
         cnt_reg <= 6'(cnt_reg + 6'h01);
      end
   end

   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         sh_reg <= 7'h00;
      end else begin
         sh_reg <= in_byte[6:0];
      end
   end

   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         busy_s1_reg <= 1'b0;
         busy_s2_reg <= 1'b0;
      end else begin
         busy_s1_reg <= BUSY | OTHER_BUSY;
         busy_s2_reg <= busy_s1_reg;
      end
   end

   // program byte lands on edges 40, 48, ... (data_edge with bit 7)
   assign data_edge = (prog_reg && cnt_reg >= sec_area_pkg::CNT_ADDR_DONE) ||
                      ((rd_param_reg || rd_area_reg) &&
                       cnt_reg == sec_area_pkg::CNT_READ_DATA);

   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         frame_reg <= '0;
         rd_param_reg <= 1'b0;
         rd_area_reg <= 1'b0;
         prog_reg <= 1'b0;
      end else begin
         if (cnt_reg == sec_area_pkg::EDGE_FIRST) begin
            frame_reg.tag <= ~frame_reg.tag;
            frame_reg.has_data <= 1'b0;
            rd_param_reg <= 1'b0;
            rd_area_reg <= 1'b0;
            prog_reg <= 1'b0;
         end
         if (cnt_reg == sec_area_pkg::EDGE_OPCODE_LAST) begin
            frame_reg.opcode <= in_byte;
            rd_param_reg <= (in_byte == sec_area_pkg::OP_PARAM_READ);
            rd_area_reg <= (in_byte == sec_area_pkg::OP_AREA_READ) && !busy_s2_reg;
            prog_reg <= (in_byte == sec_area_pkg::OP_AREA_PROGRAM) && !busy_s2_reg;
         end
         frame_reg.exact8 <= (cnt_reg == sec_area_pkg::EDGE_OPCODE_LAST);
         frame_reg.exact32 <= (cnt_reg == sec_area_pkg::EDGE_ADDR_LAST);
         if (cnt_reg >= sec_area_pkg::EDGE_ADDR_FIRST &&
             cnt_reg <= sec_area_pkg::EDGE_ADDR_LAST) begin
            frame_reg.addr <= {frame_reg.addr[22:0], SERIAL_INPUT};
         end
         if (prog_reg && data_edge && bit_reg == 3'h7) begin
            frame_reg.has_data <= 1'b1;
         end
      end
   end

   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         bit_reg <= 3'h0;
         off_reg <= 8'h00;
      end else if (cnt_reg == sec_area_pkg::EDGE_ADDR_LAST) begin
         bit_reg <= 3'h0;
         off_reg <= in_byte;
      end else if (data_edge) begin
         bit_reg <= 3'(bit_reg + 3'h1);
         if (bit_reg == 3'h7) begin
            off_reg <= 8'(off_reg + 8'h01);
         end
      end
   end

   // page buffer; only written for a program accepted while idle
   always_ff @(posedge SCLK) begin
      if (prog_reg && data_edge && bit_reg == 3'h7) begin
         pbuf[off_reg] <= in_byte;
      end
   end

   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         pmask_reg <= '0;
      end else if (cnt_reg == sec_area_pkg::EDGE_OPCODE_LAST &&
                   in_byte == sec_area_pkg::OP_AREA_PROGRAM && !busy_s2_reg) begin
         pmask_reg <= '0;
      end else if (prog_reg && data_edge && bit_reg == 3'h7) begin
         pmask_reg[off_reg] <= 1'b1;
      end
   end

   // area contents are static while no cycle runs, and reads are refused while busy
   always_comb begin
      if (rd_param_reg) begin
         rd_byte = table_byte(off_reg);
      end else begin
         rd_byte = mem[{area_num(frame_reg.addr), off_reg}];
      end
   end

   always_ff @(negedge SCLK or posedge link_rst) begin
      if (link_rst) begin
         so_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (cnt_reg == sec_area_pkg::CNT_READ_DATA &&
                   (rd_param_reg || (rd_area_reg && area_ok(frame_reg.addr)))) begin
         oe_reg <= 1'b1;
         so_reg <= rd_byte[3'(3'h7 - bit_reg)];
      end else begin
         oe_reg <= 1'b0;
         so_reg <= 1'b0;
      end
   end

   assign SERIAL_OUTPUT = so_reg;
   assign SERIAL_OUTPUT_OE = oe_reg;

   // ---------------- system domain (CLK) ----------------
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic cs_s3_reg;
   logic seen_tag_reg;
   logic new_frame;
   logic busy_any;
   logic area_unlocked;
   logic go_erase;
   logic go_prog;
   logic go_lock;
   logic go_release;
   sec_area_pkg::exec_state_t state_reg;
   logic [31:0] timer_reg;
   logic [7:0] walk_reg;
   logic walk_done_reg;
   logic [1:0] area_reg;
   logic done;
   logic wel_reg;
   logic [LOCK_UNITS-1:0] lock_reg;
   logic query_reg;
   logic release_reg;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
      end else begin
         cs_s1_reg <= CS_N;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
      end
   end

   // frame fields hold still from select high until the next frame's first edge
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         seen_tag_reg <= 1'b0;
      end else if (cs_s2_reg && !cs_s3_reg) begin
         seen_tag_reg <= frame_reg.tag;
      end
   end

   // a select pulse without clocks carries the old tag and is dropped
   assign new_frame = cs_s2_reg && !cs_s3_reg && (frame_reg.tag != seen_tag_reg);
   assign busy_any = (state_reg != sec_area_pkg::ST_IDLE) || OTHER_BUSY;
   assign area_unlocked = area_ok(frame_reg.addr) &&
                          !SECURITY_AREA_LOCK_BITS[area_num(frame_reg.addr)];
   assign go_erase = new_frame && !busy_any && wel_reg && area_unlocked &&
                     frame_reg.opcode == sec_area_pkg::OP_AREA_ERASE &&
                     frame_reg.exact32;
   assign go_prog = new_frame && !busy_any && wel_reg && area_unlocked &&
                    frame_reg.opcode == sec_area_pkg::OP_AREA_PROGRAM &&
                    frame_reg.has_data;
   assign go_lock = new_frame && !busy_any && wel_reg &&
                    frame_reg.opcode == sec_area_pkg::OP_BLOCK_LOCK &&
                    frame_reg.exact32;
   assign go_release = new_frame && !busy_any &&
                       frame_reg.opcode == sec_area_pkg::OP_RELEASE_PD &&
                       frame_reg.exact8;
   assign done = (state_reg != sec_area_pkg::ST_IDLE) && timer_reg == 32'h0 && walk_done_reg;

   // the walk touches one byte per cycle, so done also waits for the walk when a cycle count is below 257
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= sec_area_pkg::ST_IDLE;
         timer_reg <= 32'h0;
         walk_reg <= 8'h00;
         walk_done_reg <= 1'b0;
         area_reg <= 2'h0;
      end else begin
         case (state_reg)
            sec_area_pkg::ST_IDLE: begin
               walk_reg <= 8'h00;
               walk_done_reg <= 1'b0;
               area_reg <= area_num(frame_reg.addr);
               if (go_erase) begin
                  state_reg <= sec_area_pkg::ST_ERASE;
                  timer_reg <= 32'(ERASE_CYCLES - 1);
               end else if (go_prog) begin
                  state_reg <= sec_area_pkg::ST_PROGRAM;
                  timer_reg <= 32'(PROGRAM_CYCLES - 1);
               end
            end
            sec_area_pkg::ST_ERASE, sec_area_pkg::ST_PROGRAM: begin
               if (timer_reg != 32'h0) begin
                  timer_reg <= 32'(timer_reg - 32'h1);
               end
               walk_reg <= 8'(walk_reg + 8'h01);
               if (walk_reg == sec_area_pkg::WALK_LAST) begin
                  walk_done_reg <= 1'b1;
               end
               if (done) begin
                  state_reg <= sec_area_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= sec_area_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign BUSY = (state_reg != sec_area_pkg::ST_IDLE);

   // reset models a blank part; programming only clears bits
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            mem[i] <= sec_area_pkg::ERASED_BYTE;
         end
      end else if (!walk_done_reg) begin
         if (state_reg == sec_area_pkg::ST_ERASE) begin
            mem[{area_reg, walk_reg}] <= sec_area_pkg::ERASED_BYTE;
         end else if (state_reg == sec_area_pkg::ST_PROGRAM && pmask_reg[walk_reg]) begin
            mem[{area_reg, walk_reg}] <= mem[{area_reg, walk_reg}] & pbuf[walk_reg];
         end
      end
   end

   // set wins over a same-cycle clear
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wel_reg <= 1'b0;
      end else if (WEL_SET) begin
         wel_reg <= 1'b1;
      end else if (done || go_lock) begin
         wel_reg <= 1'b0;
      end
   end

   assign WRITE_ENABLE_LATCH = wel_reg;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         lock_reg <= {LOCK_UNITS{sec_area_pkg::LOCK_RESET}};
      end else if (go_lock) begin
         lock_reg[frame_reg.addr[sec_area_pkg::LOCK_IDX_LSB +: LOCK_IW]] <= 1'b1;
      end
   end

   assign BLOCK_LOCK_BITS = lock_reg;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         query_reg <= 1'b1;
         release_reg <= 1'b0;
      end else begin
         query_reg <= PROTECTION_SCHEME_SELECT ?
                      lock_reg[QUERY_ADDR[sec_area_pkg::LOCK_IDX_LSB +: LOCK_IW]] :
                      RANGE_PROTECTED;
         release_reg <= go_release;
      end
   end

   assign QUERY_PROTECTED = query_reg;
   assign RELEASE_POWER_DOWN = release_reg;
endmodule

// ==== sec_area_engine_checker.sv ====
`timescale 1ns/1ps
module sec_area_engine_checker #(
   parameter int ERASE_CYCLES = 300,
   parameter int PROGRAM_CYCLES = 300,
   parameter int LOCK_UNITS = 16
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic SERIAL_OUTPUT_OE,
   input wire logic WEL_SET,
   input wire logic WRITE_ENABLE_LATCH,
   input wire logic BUSY,
   input wire logic PROTECTION_SCHEME_SELECT,
   input wire logic RANGE_PROTECTED,
   input wire logic QUERY_PROTECTED,
   input wire logic [LOCK_UNITS-1:0] BLOCK_LOCK_BITS,
   input wire logic RELEASE_POWER_DOWN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // erase and program share busy, so bounds span both; the byte walk needs 256
   localparam int BUSY_MIN = (ERASE_CYCLES < PROGRAM_CYCLES) ? ERASE_CYCLES : PROGRAM_CYCLES;
   localparam int BUSY_LONG = (ERASE_CYCLES > PROGRAM_CYCLES) ? ERASE_CYCLES : PROGRAM_CYCLES;
   localparam int BUSY_MAX = ((BUSY_LONG > 256) ? BUSY_LONG : 256) + 1;
   int busy_cnt;
   // length of the current busy run, so both ends of the self-timed cycle are checked
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= BUSY ? busy_cnt + 1 : 0;
      end
   end
   sequence busy_hold;
      BUSY [*8];
   endsequence
   chk_locks_after_reset: assert property ($fell(RST) |-> &BLOCK_LOCK_BITS)
      else $error("block locks not all set after reset");
   chk_busy_needs_wel: assert property ($rose(BUSY) |-> WRITE_ENABLE_LATCH)
      else $error("cycle started without write enable");
   chk_busy_min_hold: assert property ($rose(BUSY) |-> busy_hold)
      else $error("busy dropped right after start");
   chk_busy_full_len: assert property ($fell(BUSY) |-> busy_cnt >= BUSY_MIN)
      else $error("self-timed cycle too short");
   chk_busy_len_cap: assert property (busy_cnt <= BUSY_MAX)
      else $error("self-timed cycle overran");
   chk_wel_clear_end: assert property (
      $fell(BUSY) && !$past(WEL_SET) |-> !WRITE_ENABLE_LATCH)
      else $error("write enable latch kept after cycle end");
   chk_release_idle: assert property (RELEASE_POWER_DOWN |-> !$past(BUSY))
      else $error("release accepted while busy");
   chk_release_pulse: assert property (RELEASE_POWER_DOWN |=> !RELEASE_POWER_DOWN)
      else $error("release pulse longer than one cycle");
   chk_query_range: assert property (
      !$past(RST) && !$past(PROTECTION_SCHEME_SELECT) |->
      QUERY_PROTECTED == $past(RANGE_PROTECTED))
      else $error("range result not used with scheme select low");
   chk_oe_released: assert property (CS_N |-> !SERIAL_OUTPUT_OE)
      else $error("output driven while deselected");
endmodule

bind sec_area_engine sec_area_engine_checker #(.ERASE_CYCLES(ERASE_CYCLES),
   .PROGRAM_CYCLES(PROGRAM_CYCLES),
   .LOCK_UNITS(LOCK_UNITS)) u_sec_area_engine_checker (.CLK(CLK), .RST(RST), .CS_N(CS_N),
   .SERIAL_OUTPUT_OE(SERIAL_OUTPUT_OE), .WEL_SET(WEL_SET),
   .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .BUSY(BUSY),
   .PROTECTION_SCHEME_SELECT(PROTECTION_SCHEME_SELECT), .RANGE_PROTECTED(RANGE_PROTECTED),
   .QUERY_PROTECTED(QUERY_PROTECTED), .BLOCK_LOCK_BITS(BLOCK_LOCK_BITS),
   .RELEASE_POWER_DOWN(RELEASE_POWER_DOWN));

// ==== spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // mode 0, 12 ns clock only inside a frame; tx is left-aligned
   task automatic frame(input logic [63:0] tx, input int nb, input int nrx,
         output logic [31:0] rx, output logic seen);
      rx = '0;
      seen = 1'b0;
      cs_n = 1'b0;
      for (int i = 0; i < nb + nrx; i++) begin
         mosi = (i < nb) ? tx[63-i] : ~mosi;
         #6 sclk = 1'b1;
         if (i >= nb) begin
            rx = {rx[30:0], miso};
            seen = seen | miso_oe;
         end
         #6 sclk = 1'b0;
      end
      #6 cs_n = 1'b1;
      // released line toggles so a stale level cannot pass for data
      mosi = ~mosi;
      #50;
   endtask
endmodule

// ==== security_area_and_param_table_access_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module security_area_and_param_table_access_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, sin, sout, soe, wel_set, write_enable_latch, other_busy, busy, pss, range_prot;
   logic qprot, rel, seen;
   logic [2:0] lock_bits;
   logic [23:0] qaddr;
   logic [15:0] blk_locks;
   logic [31:0] d;
   int n_mismatch = 0;
   int compares = 0;
   int n_rel = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   sec_area_engine #(.ERASE_CYCLES(300), .PROGRAM_CYCLES(300), .LOCK_UNITS(16))
      u_sec_area_engine (.CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n),
      .SERIAL_INPUT(sin), .SERIAL_OUTPUT(sout), .SERIAL_OUTPUT_OE(soe), .WEL_SET(wel_set),
      .WRITE_ENABLE_LATCH(write_enable_latch), .SECURITY_AREA_LOCK_BITS(lock_bits), .OTHER_BUSY(other_busy),
      .BUSY(busy), .PROTECTION_SCHEME_SELECT(pss), .RANGE_PROTECTED(range_prot),
      .QUERY_ADDR(qaddr), .QUERY_PROTECTED(qprot), .BLOCK_LOCK_BITS(blk_locks),
      .RELEASE_POWER_DOWN(rel));

   spi_host_model u_spi_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(sin), .miso(sout),
      .miso_oe(soe));

   always @(posedge clk) begin
      if (rel === 1'b1)
         n_rel++;
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         wrap_up;
      end
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic pulse_wel;
      @(negedge clk) wel_set = 1'b1;
      @(negedge clk) wel_set = 1'b0;
   endtask

   // opcode and address, eight dummy clocks, then n bytes
   task automatic rd(input logic [31:0] oa, input int n);
      u_spi_host_model.frame({oa, 32'h00000000}, 40, n * 8, d, seen);
   endtask

   // command acts a few cycles after select rises
   task automatic cmd(input logic [63:0] tx, input int nb);
      u_spi_host_model.frame(tx, nb, 0, d, seen);
      tick(6);
   endtask

   task automatic wait_idle;
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 1000) begin
         tick(1);
         k++;
      end
      `CHK(busy, 1'b0)
   endtask

   initial begin
      wel_set = 1'b0;
      lock_bits = 3'b000;
      other_busy = 1'b0;
      pss = 1'b1;
      range_prot = 1'b0;
      qaddr = 24'h050000;
      tick(16);
      rst = 1'b0;
      tick(2);
      `CHK(write_enable_latch, 1'b0)
      `CHK(blk_locks, 16'hFFFF)
      `CHK(qprot, 1'b1)
      rd(32'h5A000004, 2);
      `CHK(d[15:0], 16'h0103)
      rd(32'h5A0000FF, 2);
      `CHK(d[15:0], {8'hFF, sec_area_pkg::PARAM_SIGNATURE[31:24]})
      rd(32'h48001000, 1);
      `CHK(d[7:0], 8'hFF)
      cmd({32'h44001000, 32'h0}, 32);
      `CHK(busy, 1'b0)
      pulse_wel;
      cmd({32'h44002000, 32'h0}, 33);
      `CHK(busy, 1'b0)
      `CHK(write_enable_latch, 1'b1)
      cmd({32'h420020FE, 16'hA53C, 16'h0000}, 48);
      `CHK(busy, 1'b1)
      wait_idle;
      `CHK(write_enable_latch, 1'b0)
      rd(32'h480020FE, 3);
      `CHK(d[23:0], 24'hA53CFF)
      pulse_wel;
      cmd({32'h44002000, 32'h0}, 32);
      `CHK(busy, 1'b1)
      rd(32'h480020FE, 1);
      `CHK(seen, 1'b0)
      cmd({8'hAB, 56'h0}, 8);
      `CHK(n_rel, 0)
      `CHK(busy, 1'b1)
      wait_idle;
      `CHK(write_enable_latch, 1'b0)
      rd(32'h480020FE, 2);
      `CHK(d[15:0], 16'hFFFF)
      rd(32'h48004000, 1);
      `CHK(seen, 1'b0)
      @(negedge clk) other_busy = 1'b1;
      rd(32'h48001000, 1);
      `CHK(seen, 1'b0)
      @(negedge clk) other_busy = 1'b0;
      cmd({8'hAB, 56'h0}, 8);
      `CHK(n_rel, 1)
      @(negedge clk) lock_bits = 3'b100;
      pulse_wel;
      cmd({32'h42003000, 32'h0}, 40);
      `CHK(busy, 1'b0)
      `CHK(write_enable_latch, 1'b1)
      rd(32'h48003000, 1);
      `CHK(d[7:0], 8'hFF)
      cmd({32'h36050000, 32'h0}, 32);
      `CHK(write_enable_latch, 1'b0)
      `CHK(blk_locks[5], 1'b1)
      @(negedge clk) pss = 1'b0;
      range_prot = 1'b1;
      tick(2);
      `CHK(qprot, 1'b1)
      range_prot = 1'b0;
      tick(2);
      `CHK(qprot, 1'b0)
      wrap_up;
   end
endmodule
